/* File: hw/rag_pkg.sv */
package rag_pkg;

    // ==========================================================
    // widths
    localparam int RAG_PC_W = 14;
    localparam int RAG_WORD_W = 10;
    localparam int RAG_AW = 10;
    localparam int RAG_NIB = 4;

    // ==========================================================
    // ram map
    localparam logic [9:0] RAG_BANK_ADDR = 10'h03f;
    localparam logic [9:0] RAG_BANK_LO = 10'h090;
    localparam logic [9:0] RAG_BANK_HI = 10'h25f;
    localparam logic [9:0] RAG_MEMREG_BASE = 10'h040;

    // ==========================================================
    // reset values
    localparam logic [13:0] RAG_PC_RST = 14'h0000;
    localparam logic [3:0] RAG_NIB_RST = 4'h0;
    localparam logic [1:0] RAG_W_RST = 2'h0;

    // ==========================================================
    // opcode values and masks
    localparam logic [9:0] RAG_M_EXACT = 10'h3ff;
    localparam logic [9:0] RAG_M_NIB = 10'h3f0;
    localparam logic [9:0] RAG_M_TWO = 10'h3fc;
    localparam logic [9:0] RAG_M_SIX = 10'h3c0;
    localparam logic [9:0] RAG_M_BYTE = 10'h300;
    localparam logic [9:0] RAG_OP_SHORT_BR = 10'h300;
    localparam logic [9:0] RAG_OP_LONG_JUMP = 10'h150;
    localparam logic [9:0] RAG_OP_LONG_BRANCH = 10'h160;
    localparam logic [9:0] RAG_OP_LONG_CALL = 10'h170;
    localparam logic [9:0] RAG_OP_ZERO_CALL = 10'h1c0;
    localparam logic [9:0] RAG_OP_TABLE_BR = 10'h0b0;
    localparam logic [9:0] RAG_OP_TABLE_REF = 10'h060;
    localparam logic [9:0] RAG_OP_LOAD_MEMREG = 10'h0e0;
    localparam logic [9:0] RAG_OP_SWAP_MEMREG = 10'h1a0;
    localparam logic [9:0] RAG_OP_LOAD_IND = 10'h090;
    localparam logic [9:0] RAG_OP_STORE_IND = 10'h094;
    localparam logic [9:0] RAG_OP_LOAD_DIR = 10'h190;
    localparam logic [9:0] RAG_OP_STORE_DIR = 10'h194;
    localparam logic [9:0] RAG_OP_SET_W = 10'h0f0;
    localparam logic [9:0] RAG_OP_SET_X = 10'h220;
    localparam logic [9:0] RAG_OP_SET_Y = 10'h210;
    localparam logic [9:0] RAG_OP_SET_A = 10'h230;
    localparam logic [9:0] RAG_OP_SET_B = 10'h200;

    // ==========================================================
    // table word flag bits
    localparam int RAG_TBL_AB_BIT = 8;
    localparam int RAG_TBL_PORT_BIT = 9;

    typedef enum logic [1:0] {
        RAG_ST_FETCH,
        RAG_ST_SECOND,
        RAG_ST_TABLE,
        RAG_ST_RAMRD
    } rag_state_type;

    typedef enum logic [2:0] {
        RAG_PEND_NONE,
        RAG_PEND_JUMP,
        RAG_PEND_CALL,
        RAG_PEND_LOAD,
        RAG_PEND_STORE,
        RAG_PEND_SWAP
    } rag_pend_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [9:0] addr;
        logic [3:0] bank;
        logic [3:0] wdata;
    } rag_ram_req_type;

    typedef struct packed {
        logic rd;
        logic [13:0] addr;
    } rag_tbl_req_type;

endpackage

/* File: hw/rag_core.sv */
`timescale 1ns/1ps
// Operation
// - indirect ram address is pointer registers w, x, y concatenated, ten bits
// - indirect accesses from 090 to 25f also carry the bank register at 03f
// - direct ram ops take two words; second word is the ten-bit address
// - sixteen memory registers at 040..04f, reached by load and swap ops and also by direct and indirect ram ops
// - long jump, branch and call load all fourteen counter bits
// - rom is 64 pages of 256 words; upper bits page, low eight word
// - short branch replaces the eight low bits of the incremented counter
// - zero-page call loads six low bits and clears the eight upper bits
// - table branch target built from four-bit field, accumulator and b
// - table word bit 8 set writes low byte into accumulator and b
// - table word bit 9 set writes low byte into port one and two outputs
// - both flag bits set update both pairs in the same cycle
// - table reference never changes counter sequencing
// - short branch on a page's last word lands in the following page
module rag_core (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // instruction fetch
    input wire logic instr_valid_i,
    input wire logic [rag_pkg::RAG_WORD_W-1:0] instr_word_i,
    output logic ready_o,
    output logic [rag_pkg::RAG_PC_W-1:0] program_counter_o,
    // subroutine push
    output logic push_o,
    output logic [rag_pkg::RAG_PC_W-1:0] push_addr_o,
    // data ram
    output rag_pkg::rag_ram_req_type ram_req_o,
    input wire logic [rag_pkg::RAG_NIB-1:0] ram_rdata_i,
    // table data rom port
    output rag_pkg::rag_tbl_req_type tbl_req_o,
    input wire logic tbl_valid_i,
    input wire logic [rag_pkg::RAG_WORD_W-1:0] tbl_data_i,
    // register state
    output logic [rag_pkg::RAG_NIB-1:0] acc_o,
    output logic [rag_pkg::RAG_NIB-1:0] b_o,
    output logic [rag_pkg::RAG_NIB-1:0] ram_bank_select_o,
    output logic [rag_pkg::RAG_NIB-1:0] port_one_output_o,
    output logic [rag_pkg::RAG_NIB-1:0] port_two_output_o
);
    import rag_pkg::*;

    function automatic logic op_is(input logic [9:0] w, input logic [9:0] m,
                                   input logic [9:0] v);
        op_is = (w & m) == v;
    endfunction

    // bank register only reaches ram inside its window
    function automatic logic [3:0] bank_for(input logic [9:0] a, input logic [3:0] sel);
        bank_for = (a >= RAG_BANK_LO && a <= RAG_BANK_HI) ? sel : RAG_NIB_RST;
    endfunction

    // ==========================================================
    // state
    rag_state_type state_q, state_d;
    rag_pend_type pend_q, pend_d;
    logic [13:0] pc_q, pc_d;
    logic [3:0] hi_q, hi_d;
    logic [1:0] w_q, w_d;
    logic [3:0] x_q, x_d;
    logic [3:0] y_q, y_d;
    logic [3:0] a_q, a_d;
    logic [3:0] b_q, b_d;
    logic [3:0] bank_q, bank_d;
    logic [3:0] p1_q, p1_d;
    logic [3:0] p2_q, p2_d;
    logic [9:0] rd_addr_q, rd_addr_d;
    rag_ram_req_type ram_q, ram_d;
    rag_tbl_req_type tbl_q, tbl_d;
    logic push_q, push_d;
    logic [13:0] push_addr_q, push_addr_d;
    logic ready_q;

    // ==========================================================
    // decode
    wire [9:0] iw = instr_word_i;
    wire take = instr_valid_i && (state_q == RAG_ST_FETCH || state_q == RAG_ST_SECOND);
    wire first = take && state_q == RAG_ST_FETCH;
    wire second = take && state_q == RAG_ST_SECOND;
    wire [13:0] pc_inc = pc_q + 14'h0001;
    wire [9:0] ind_addr = {w_q, x_q, y_q};
    wire [9:0] memreg_addr = RAG_MEMREG_BASE | {6'h00, iw[3:0]};
    // table target: field, two zero bits, accumulator, b
    wire [13:0] tbl_target = {iw[3:0], 2'b00, a_q, b_q};
    wire d_short = op_is(iw, RAG_M_BYTE, RAG_OP_SHORT_BR);
    wire d_jump = op_is(iw, RAG_M_NIB, RAG_OP_LONG_JUMP)
        || op_is(iw, RAG_M_NIB, RAG_OP_LONG_BRANCH);
    wire d_lcall = op_is(iw, RAG_M_NIB, RAG_OP_LONG_CALL);
    wire d_zcall = op_is(iw, RAG_M_SIX, RAG_OP_ZERO_CALL);
    wire d_tjmp = op_is(iw, RAG_M_NIB, RAG_OP_TABLE_BR);
    wire d_tref = op_is(iw, RAG_M_NIB, RAG_OP_TABLE_REF);
    wire d_lmr = op_is(iw, RAG_M_NIB, RAG_OP_LOAD_MEMREG);
    wire d_xmr = op_is(iw, RAG_M_NIB, RAG_OP_SWAP_MEMREG);
    wire d_lind = op_is(iw, RAG_M_EXACT, RAG_OP_LOAD_IND);
    wire d_sind = op_is(iw, RAG_M_EXACT, RAG_OP_STORE_IND);
    wire d_ldir = op_is(iw, RAG_M_EXACT, RAG_OP_LOAD_DIR);
    wire d_sdir = op_is(iw, RAG_M_EXACT, RAG_OP_STORE_DIR);
    wire d_setw = op_is(iw, RAG_M_TWO, RAG_OP_SET_W);
    wire d_setx = op_is(iw, RAG_M_NIB, RAG_OP_SET_X);
    wire d_sety = op_is(iw, RAG_M_NIB, RAG_OP_SET_Y);
    wire d_seta = op_is(iw, RAG_M_NIB, RAG_OP_SET_A);
    wire d_setb = op_is(iw, RAG_M_NIB, RAG_OP_SET_B);
    wire tbl_ab = tbl_data_i[RAG_TBL_AB_BIT];
    wire tbl_port = tbl_data_i[RAG_TBL_PORT_BIT];

    // ==========================================================
    // next state
    always_comb begin
        state_d = state_q;
        pend_d = pend_q;
        pc_d = pc_q;
        hi_d = hi_q;
        w_d = w_q;
        x_d = x_q;
        y_d = y_q;
        a_d = a_q;
        b_d = b_q;
        bank_d = bank_q;
        p1_d = p1_q;
        p2_d = p2_q;
        rd_addr_d = rd_addr_q;
        ram_d = '0;
        tbl_d = '0;
        push_d = 1'b0;
        push_addr_d = push_addr_q;
        if (take) begin
            pc_d = pc_inc;
        end
        case (state_q)
            RAG_ST_FETCH: begin
                if (first) begin
                    if (d_short) begin
                        // incremented page: last word of a page jumps into the next
                        pc_d = {pc_inc[13:8], iw[7:0]};
                    end else if (d_jump || d_lcall) begin
                        hi_d = iw[3:0];
                        pend_d = d_lcall ? RAG_PEND_CALL : RAG_PEND_JUMP;
                        state_d = RAG_ST_SECOND;
                    end else if (d_zcall) begin
                        pc_d = {8'h00, iw[5:0]};
                        push_d = 1'b1;
                        push_addr_d = pc_inc;
                    end else if (d_tjmp) begin
                        pc_d = tbl_target;
                    end else if (d_tref) begin
                        // counter keeps its plain increment
                        tbl_d.rd = 1'b1;
                        tbl_d.addr = tbl_target;
                        state_d = RAG_ST_TABLE;
                    end else if (d_lmr || d_xmr) begin
                        ram_d.rd = 1'b1;
                        ram_d.addr = memreg_addr;
                        rd_addr_d = memreg_addr;
                        pend_d = d_xmr ? RAG_PEND_SWAP : RAG_PEND_LOAD;
                        state_d = RAG_ST_RAMRD;
                    end else if (d_lind) begin
                        ram_d.rd = 1'b1;
                        ram_d.addr = ind_addr;
                        ram_d.bank = bank_for(ind_addr, bank_q);
                        rd_addr_d = ind_addr;
                        pend_d = RAG_PEND_LOAD;
                        state_d = RAG_ST_RAMRD;
                    end else if (d_sind) begin
                        ram_d.wr = 1'b1;
                        ram_d.addr = ind_addr;
                        ram_d.bank = bank_for(ind_addr, bank_q);
                        ram_d.wdata = a_q;
                    end else if (d_ldir || d_sdir) begin
                        pend_d = d_ldir ? RAG_PEND_LOAD : RAG_PEND_STORE;
                        state_d = RAG_ST_SECOND;
                    end else if (d_setw) begin
                        w_d = iw[1:0];
                    end else if (d_setx) begin
                        x_d = iw[3:0];
                    end else if (d_sety) begin
                        y_d = iw[3:0];
                    end else if (d_seta) begin
                        a_d = iw[3:0];
                    end else if (d_setb) begin
                        b_d = iw[3:0];
                    end
                end
            end
            RAG_ST_SECOND: begin
                if (second) begin
                    state_d = RAG_ST_FETCH;
                    pend_d = RAG_PEND_NONE;
                    case (pend_q)
                        RAG_PEND_JUMP: begin
                            pc_d = {hi_q, iw};
                        end
                        RAG_PEND_CALL: begin
                            pc_d = {hi_q, iw};
                            push_d = 1'b1;
                            push_addr_d = pc_inc;
                        end
                        RAG_PEND_LOAD: begin
                            ram_d.rd = 1'b1;
                            ram_d.addr = iw;
                            rd_addr_d = iw;
                            pend_d = RAG_PEND_LOAD;
                            state_d = RAG_ST_RAMRD;
                        end
                        RAG_PEND_STORE: begin
                            ram_d.wr = 1'b1;
                            ram_d.addr = iw;
                            ram_d.wdata = a_q;
                        end
                        default: begin
                            state_d = RAG_ST_FETCH;
                        end
                    endcase
                end
            end
            RAG_ST_TABLE: begin
                if (tbl_valid_i) begin
                    // both flags update both pairs in this one cycle
                    if (tbl_ab) begin
                        {b_d, a_d} = tbl_data_i[7:0];
                    end
                    if (tbl_port) begin
                        {p2_d, p1_d} = tbl_data_i[7:0];
                    end
                    state_d = RAG_ST_FETCH;
                end
            end
            RAG_ST_RAMRD: begin
                // ram answers in the same cycle the registered read strobe stands
                a_d = ram_rdata_i;
                if (pend_q == RAG_PEND_SWAP) begin
                    ram_d.wr = 1'b1;
                    ram_d.addr = rd_addr_q;
                    ram_d.wdata = a_q;
                end
                pend_d = RAG_PEND_NONE;
                state_d = RAG_ST_FETCH;
            end
            default: begin
                state_d = RAG_ST_FETCH;
                pend_d = RAG_PEND_NONE;
            end
        endcase
        // bank register shadows every write to its ram address
        if (ram_d.wr && ram_d.addr == RAG_BANK_ADDR) begin
            bank_d = ram_d.wdata;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= RAG_ST_FETCH;
            pend_q <= RAG_PEND_NONE;
            pc_q <= RAG_PC_RST;
            hi_q <= RAG_NIB_RST;
            w_q <= RAG_W_RST;
            x_q <= RAG_NIB_RST;
            y_q <= RAG_NIB_RST;
            a_q <= RAG_NIB_RST;
            b_q <= RAG_NIB_RST;
            bank_q <= RAG_NIB_RST;
            p1_q <= RAG_NIB_RST;
            p2_q <= RAG_NIB_RST;
            rd_addr_q <= RAG_MEMREG_BASE;
            ram_q <= '0;
            tbl_q <= '0;
            push_q <= 1'b0;
            push_addr_q <= RAG_PC_RST;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            pend_q <= pend_d;
            pc_q <= pc_d;
            hi_q <= hi_d;
            w_q <= w_d;
            x_q <= x_d;
            y_q <= y_d;
            a_q <= a_d;
            b_q <= b_d;
            bank_q <= bank_d;
            p1_q <= p1_d;
            p2_q <= p2_d;
            rd_addr_q <= rd_addr_d;
            ram_q <= ram_d;
            tbl_q <= tbl_d;
            push_q <= push_d;
            push_addr_q <= push_addr_d;
            ready_q <= state_d == RAG_ST_FETCH || state_d == RAG_ST_SECOND;
        end
    end

    // ==========================================================
    // outputs
    assign ready_o = ready_q;
    assign program_counter_o = pc_q;
    assign push_o = push_q;
    assign push_addr_o = push_addr_q;
    assign ram_req_o = ram_q;
    assign tbl_req_o = tbl_q;
    assign acc_o = a_q;
    assign b_o = b_q;
    assign ram_bank_select_o = bank_q;
    assign port_one_output_o = p1_q;
    assign port_two_output_o = p2_q;

endmodule // rag_core

/* File: bench/rag_core_assertions.sv */
`timescale 1ns/1ps
module rag_core_assertions (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // fetch
    input wire logic instr_valid_i,
    input wire logic [9:0] instr_word_i,
    input wire logic ready_o,
    input wire logic [13:0] program_counter_o,
    // memories
    input wire rag_pkg::rag_ram_req_type ram_req_o,
    input wire rag_pkg::rag_tbl_req_type tbl_req_o,
    input wire logic tbl_valid_i,
    input wire logic [9:0] tbl_data_i,
    // registers
    input wire logic [3:0] acc_o,
    input wire logic [3:0] b_o,
    input wire logic [3:0] port_one_output_o,
    input wire logic [3:0] port_two_output_o
);
    import rag_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // ======
    // word tracking, so a second word is never read as an opcode
    logic sec_q;
    logic lng_q;
    logic [3:0] k_q;
    wire [9:0] w = instr_word_i;
    wire tk = instr_valid_i && ready_o;
    wire fst = tk && !sec_q;
    wire lng = w[9:4] == 6'h15 || w[9:4] == 6'h16 || w[9:4] == 6'h17;
    wire dir = w == RAG_OP_LOAD_DIR || w == RAG_OP_STORE_DIR;
    wire [9:0] wn = w & RAG_M_NIB;
    wire mrop = fst && (wn == RAG_OP_LOAD_MEMREG || wn == RAG_OP_SWAP_MEMREG);
    wire [13:0] pc_inc = program_counter_o + 14'h1;
    wire [13:0] sb_t = {pc_inc[13:8], w[7:0]};
    wire [13:0] zc_t = {8'h00, w[5:0]};
    wire [13:0] tb_t = {w[3:0], 2'b00, acc_o, b_o};
    wire [13:0] lj_t = {k_q, w};
    wire [9:0] memreg_a = {6'h04, w[3:0]};
    wire [7:0] td = tbl_data_i[7:0];
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sec_q <= 1'b0;
            lng_q <= 1'b0;
            k_q <= 4'h0;
        end else if (tk) begin
            sec_q <= !sec_q && (lng || dir);
            lng_q <= lng;
            k_q <= w[3:0];
        end
    end
    // ======
    // properties
    property p_short;
        fst && w[9:8] == 2'b11 |=> program_counter_o == $past(sb_t);
    endproperty
    a_short: assert property (p_short) else $error("short branch target");
    property p_zero;
        fst && (w & RAG_M_SIX) == RAG_OP_ZERO_CALL |=> program_counter_o == $past(zc_t);
    endproperty
    a_zero: assert property (p_zero) else $error("zero call target");
    property p_long;
        tk && sec_q && lng_q |=> program_counter_o == $past(lj_t);
    endproperty
    a_long: assert property (p_long) else $error("long target");
    property p_dir;
        tk && sec_q && !lng_q |=> (ram_req_o.rd || ram_req_o.wr)
            && ram_req_o.addr == $past(w) && ram_req_o.bank == 4'h0;
    endproperty
    a_dir: assert property (p_dir) else $error("direct address");
    property p_mr;
        mrop |=> ram_req_o.rd && ram_req_o.addr == $past(memreg_a) && !ready_o;
    endproperty
    a_mr: assert property (p_mr) else $error("memory register address");
    property p_tref;
        fst && wn == RAG_OP_TABLE_REF |=> tbl_req_o.rd
            && tbl_req_o.addr == $past(tb_t) && program_counter_o == $past(pc_inc);
    endproperty
    a_tref: assert property (p_tref) else $error("table read");
    property p_tab;
        tbl_valid_i && !ready_o && tbl_data_i[8] |=> ready_o && {b_o, acc_o} == $past(td);
    endproperty
    a_tab: assert property (p_tab) else $error("table to acc");
    property p_port;
        tbl_valid_i && !ready_o && tbl_data_i[9]
            |=> {port_two_output_o, port_one_output_o} == $past(td);
    endproperty
    a_port: assert property (p_port) else $error("table to ports");
    property p_bank;
        (ram_req_o.rd || ram_req_o.wr) && (ram_req_o.addr < RAG_BANK_LO
            || ram_req_o.addr > RAG_BANK_HI) |-> ram_req_o.bank == 4'h0;
    endproperty
    a_bank: assert property (p_bank) else $error("bank outside range");
endmodule // rag_core_assertions

bind rag_core rag_core_assertions rag_core_assertions_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_word_i(instr_word_i), .ready_o(ready_o), .program_counter_o(program_counter_o),
    .ram_req_o(ram_req_o), .tbl_req_o(tbl_req_o), .tbl_valid_i(tbl_valid_i),
    .tbl_data_i(tbl_data_i), .acc_o(acc_o), .b_o(b_o),
    .port_one_output_o(port_one_output_o), .port_two_output_o(port_two_output_o)
);

/* File: bench/rag_mem_model.sv */
`timescale 1ns/1ps
module rag_mem_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // data ram
    input wire rag_pkg::rag_ram_req_type ram_req_i,
    output logic [3:0] ram_rdata_o,
    // table rom, word and delay chosen by the bench
    input wire rag_pkg::rag_tbl_req_type tbl_req_i,
    input wire logic [9:0] tbl_word_i,
    input wire logic [3:0] tbl_lat_i,
    output logic tbl_valid_o,
    output logic [9:0] tbl_data_o
);
    import rag_pkg::*;
    // ======
    // ram, bank in the upper index bits
    logic [3:0] mem [0:16383];
    logic [4:0] cnt_q;
    logic [3:0] stale_q = 4'h5;
    // the core samples read data in the cycle its read strobe stands, so the read is direct
    assign ram_rdata_o = ram_req_i.rd ? mem[{ram_req_i.bank, ram_req_i.addr}] : stale_q;
    // stale data flips every cycle so a mistimed sample never matches
    always @(posedge clk_sys_i) begin
        if (ram_req_i.wr) begin
            mem[{ram_req_i.bank, ram_req_i.addr}] <= ram_req_i.wdata;
        end
        stale_q <= ~stale_q;
    end
    // ======
    // table rom answers after a bench-set delay
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 5'h0;
            tbl_valid_o <= 1'b0;
            tbl_data_o <= 10'h2aa;
        end else begin
            cnt_q <= tbl_req_i.rd ? 5'(tbl_lat_i) + 5'h1 : cnt_q - 5'(cnt_q != 5'h0);
            tbl_valid_o <= cnt_q == 5'h1;
            tbl_data_o <= (cnt_q == 5'h1) ? tbl_word_i : ~tbl_data_o;
        end
    end
endmodule // rag_mem_model

/* File: bench/ram_rom_address_generation_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module ram_rom_address_generation_bench;
    import rag_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic valid = 1'b0;
    logic ready, tval, inr, push;
    logic [9:0] word = 10'h0, tword = 10'h0, tdat, a, tw;
    logic [3:0] tlat = 4'h0, rdat, acc, b, bank, p1, p2, x, bsel, ea, eb;
    logic [3:0] e1 = 4'h0, e2 = 4'h0;
    logic [13:0] pc, paddr, t, r, ep = 14'h0;
    logic [7:0] d;
    logic [9:0] edges [4] = '{10'h090, 10'h25f, 10'h08f, 10'h260};
    rag_ram_req_type ram_req;
    rag_tbl_req_type tbl_req;
    int n_fail = 0;
    int checked = 0;
    int n_push = 0;
    rag_core rag_core_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(valid),
        .instr_word_i(word), .ready_o(ready), .program_counter_o(pc), .push_o(push),
        .push_addr_o(paddr), .ram_req_o(ram_req), .ram_rdata_i(rdat), .tbl_req_o(tbl_req),
        .tbl_valid_i(tval), .tbl_data_i(tdat), .acc_o(acc), .b_o(b),
        .ram_bank_select_o(bank), .port_one_output_o(p1), .port_two_output_o(p2));
    rag_mem_model rag_mem_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .ram_req_i(ram_req), .ram_rdata_o(rdat), .tbl_req_i(tbl_req), .tbl_word_i(tword),
        .tbl_lat_i(tlat), .tbl_valid_o(tval), .tbl_data_o(tdat));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // every completed call pulses the push strobe once
    always @(posedge clk_sys_i) begin
        if (push === 1'b1) begin
            n_push <= n_push + 1;
        end
    end
    // ======
    // tasks
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one word, then wait until the block is ready again
    task automatic send(input logic [9:0] w);
        int n;
        n = 0;
        valid <= 1'b1;
        word <= w;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ready !== 1'b1 && n < 60);
        valid <= 1'b0;
        ep++;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ready !== 1'b1 && n < 60);
        if (n >= 60) begin
            n_fail++;
            stop_test();
        end
    endtask
    task automatic st(input logic [9:0] ad, input logic [3:0] dt);
        send(RAG_OP_SET_A | 10'(dt));
        send(RAG_OP_STORE_DIR);
        send(ad);
    endtask
    // ======
    // main sequence
    initial begin
        void'($urandom(32'h5d717929));
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int i = 0; i < 24; i++) begin
            t = 14'($urandom);
            if (i % 2 == 1) t[7:0] = 8'hfe;
            r = ep + 14'h2;
            x = 4'($urandom);
            send(RAG_OP_LONG_JUMP + 10'(16 * (i % 3)) | 10'(t[13:10]));
            send(t[9:0]);
            ep = t;
            `CHK("pc", ep, pc)
            if (i % 3 == 2) `CHK("ret", r, paddr)
            send(RAG_OP_SET_A | 10'(x));
            `CHK("pc", ep, pc)
            d = 8'($urandom);
            send(RAG_OP_SHORT_BR | 10'(d));
            ep[7:0] = d;
            `CHK("pc", ep, pc)
        end
        r = ep + 14'h1;
        send(RAG_OP_ZERO_CALL | 10'(d[5:0]));
        ep = {8'h00, d[5:0]};
        `CHK("pc", ep, pc)
        `CHK("ret", r, paddr)
        for (int i = 0; i < 16; i++) begin
            ea = 4'($urandom);
            eb = 4'($urandom);
            x = 4'($urandom);
            tw = 10'($urandom);
            tw[9:8] = 2'(i);
            tword <= tw;
            tlat <= 4'($urandom % 6);
            send(RAG_OP_SET_A | 10'(ea));
            send(RAG_OP_SET_B | 10'(eb));
            send(RAG_OP_TABLE_REF | 10'(x));
            `CHK("pc", ep, pc)
            if (tw[8]) {eb, ea} = tw[7:0];
            if (tw[9]) {e2, e1} = tw[7:0];
            `CHK("accb", {eb, ea}, {b, acc})
            `CHK("ports", {e2, e1}, {p2, p1})
            send(RAG_OP_TABLE_BR | 10'(x));
            ep = {x, 2'b00, ea, eb};
            `CHK("pc", ep, pc)
        end
        for (int i = 0; i < 8; i++) begin
            x = 4'($urandom);
            ea = 4'($urandom);
            eb = ~ea;
            st(10'h040 | 10'(x), ea);
            send(RAG_OP_SET_A | 10'(eb));
            send(RAG_OP_SWAP_MEMREG | 10'(x));
            `CHK("acc", ea, acc)
            send(RAG_OP_LOAD_MEMREG | 10'(x));
            `CHK("acc", eb, acc)
            send(RAG_OP_LOAD_DIR);
            send(10'h040 | 10'(x));
            `CHK("acc", eb, acc)
            a = (i < 4) ? edges[i] : 10'h090 + 10'($urandom % 464);
            bsel = 4'($urandom | 1);
            send(RAG_OP_SET_W | 10'(a[9:8]));
            send(RAG_OP_SET_X | 10'(a[7:4]));
            send(RAG_OP_SET_Y | 10'(a[3:0]));
            st(RAG_BANK_ADDR, bsel);
            `CHK("bank", bsel, bank)
            send(RAG_OP_SET_A | 10'(ea));
            send(RAG_OP_STORE_IND);
            st(RAG_BANK_ADDR, ~bsel);
            send(RAG_OP_SET_A | 10'(eb));
            send(RAG_OP_STORE_IND);
            st(RAG_BANK_ADDR, bsel);
            send(RAG_OP_LOAD_IND);
            inr = a >= RAG_BANK_LO && a <= RAG_BANK_HI;
            `CHK("ind", inr ? ea : eb, acc)
        end
        `CHK("pc", ep, pc)
        // eight long calls in the first loop and one zero-page call
        `CHK("push", 9, n_push)
        stop_test();
    end
    // a hang is cut at 10000 cycles, well past the several hundred cycles the run needs
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
endmodule // ram_rom_address_generation_bench
